// ===== hw/cutter_control_input_port.sv
// Control-input and parameter port of the rotary-cutter controller.
// Assumes pins are asynchronous, line_pos and roll/line status come from the
// motion logic on aclk, and software uses AXI4-Lite.
`default_nettype none
// Notes on behaviour
// - Latch data on strobe rising edge only
// - No maximum setup or hold time
// - Reset high disables closed-loop control
// - Reset with start/stop high restarts startup
// - Trim inputs shift cut position while high
// - Trim jogs roll when line stationary
// - Latch stores word in selected buffer
// - Commit rising edge copies buffers to active
// - Latch and commit together work in one step
// - Two parameter sets chosen by select
// - Set change only at startup or restart, or at a standstill stop
// - Store rising edge writes nonvolatile copy
// - Stop request finishes the next cut first
// - Mark with counter reset defines valid mark
// - Mark rising edge plus sensor distance
// - Missing mark cuts at expected position
// - Spacing jump restarts search, flags tolerance
// - Twelve control inputs, twelve control outputs
// - Four select lines, twenty data lines
// - Data read as BCD or binary
// - Power-up loads set from nonvolatile memory
module cutter_control_input_port
   import cutter_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              reset_in,
   input  wire logic              trim_fwd_in,
   input  wire logic              trim_rev_in,
   input  wire logic              buffer_latch_strobe,
   input  wire logic              buffer_commit_strobe,
   input  wire logic              parameter_set_select,
   input  wire logic              nonvolatile_store_strobe,
   input  wire logic              start_stop,
   input  wire logic              mark_counter_reset,
   input  wire logic              print_mark,
   input  wire logic              cutting_pulse,
   input  wire logic              aux_in,
   input  wire logic [SEL_W-1:0]  param_select,
   input  wire logic [DATA_W-1:0] param_data,
   input  wire logic              line_stationary,
   input  wire logic              roll_standstill,
   input  wire logic [31:0]       line_pos,
   output logic                   ready_out,
   output logic                   closed_loop_enable,
   output logic                   startup_pulse,
   output logic                   cutting_active,
   output logic                   jog_fwd,
   output logic                   jog_rev,
   output logic                   mark_window_open,
   output logic                   cut_too_short,
   output logic                   cut_too_long,
   output logic                   trim_fwd_out,
   output logic                   trim_rev_out,
   output logic                   phase_ref_pulse,
   output logic [31:0]            cut_target,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   function automatic logic [DATA_W-1:0] bcd_to_bin(input logic [DATA_W-1:0] v);
      logic [DATA_W-1:0] r;
      r = '0;
      for (int i = 4; i >= 0; i--) begin
         r = DATA_W'(r * 20'hA) + {16'h0, v[i*4 +: 4]};
      end
      return r;
   endfunction

   // -------------------------------------------------
   // Input synchronisers and edge detection
   // -------------------------------------------------
   logic [NUM_PINS-1:0] pin_s1_r, pin_s2_r, pin_d_r;
   logic [SEL_W-1:0]    sel_s1_r, sel_s2_r;
   logic [DATA_W-1:0]   dat_s1_r, dat_s2_r;
   wire  [NUM_PINS-1:0] pin_raw = {aux_in, cutting_pulse, print_mark, mark_counter_reset,
                                   start_stop, nonvolatile_store_strobe, parameter_set_select,
                                   buffer_commit_strobe, buffer_latch_strobe, trim_rev_in,
                                   trim_fwd_in, reset_in};
   wire  [NUM_PINS-1:0] rise = pin_s2_r & ~pin_d_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_d_r  <= '0;
         sel_s1_r <= '0;
         sel_s2_r <= '0;
         dat_s1_r <= '0;
         dat_s2_r <= '0;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         pin_d_r  <= pin_s2_r;
         sel_s1_r <= param_select;
         sel_s2_r <= sel_s1_r;
         dat_s1_r <= param_data;
         dat_s2_r <= dat_s1_r;
      end
   end

   wire latch_rise  = rise[PIN_LATCH];
   wire commit_rise = rise[PIN_COMMIT];
   wire store_rise  = rise[PIN_STORE];
   wire mark_rise   = rise[PIN_MARK];
   wire cut_rise    = rise[PIN_CUT];
   wire start_hi    = pin_s2_r[PIN_START];

   // -------------------------------------------------
   // Sequencer: startup load, run, stop after next cut
   // -------------------------------------------------
   ctl_state_e state_r;
   logic [1:0] load_cnt_r;
   logic       active_set_r, ready_r, startup_r;
   logic [1:0] ctrl_r;
   wire  set_req    = pin_s2_r[PIN_SETSEL];
   wire  restart    = rise[PIN_RESET] & start_hi;
   wire  load_go    = (state_r == ST_LOAD) && (load_cnt_r == LOAD_WAIT);
   wire  switch_go  = (state_r == ST_STOPPED) && roll_standstill
                      && (set_req != active_set_r);
   wire  reload_go  = load_go | switch_go;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r      <= ST_LOAD;
         load_cnt_r   <= '0;
         active_set_r <= 1'b0;
         ready_r      <= 1'b0;
         startup_r    <= 1'b0;
      end else begin
         startup_r <= restart;
         if (reload_go) begin
            active_set_r <= set_req;
         end
         if (restart) begin
            state_r    <= ST_LOAD;
            load_cnt_r <= '0;
            ready_r    <= 1'b0;
         end else begin
            unique case (state_r)
               ST_LOAD: begin
                  load_cnt_r <= load_cnt_r + 2'h1;
                  if (load_go) begin
                     ready_r <= 1'b1;
                     state_r <= start_hi ? ST_STOPPED : ST_RUN;
                  end
               end
               ST_RUN: if (start_hi) begin
                  state_r <= ST_STOPPING;
               end
               ST_STOPPING: begin
                  if (!start_hi) begin
                     state_r <= ST_RUN;
                  end else if (cut_rise) begin
                     state_r <= ST_STOPPED;
                  end
               end
               ST_STOPPED: if (!start_hi) begin
                  state_r <= ST_RUN;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------
   // Buffer, active and nonvolatile parameter memories
   // -------------------------------------------------
   // The nonvolatile image has no reset: it must survive a power cycle.
   logic [DATA_W-1:0] buf_mem [NUM_BUF];
   logic [DATA_W-1:0] act_mem [NUM_BUF];
   logic [DATA_W-1:0] nv_mem  [NUM_SETS][NUM_BUF];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_BUF; i++) begin
            buf_mem[i] <= '0;
         end
      end else if (latch_rise) begin
         buf_mem[sel_s2_r] <= dat_s2_r;
      end
   end

   always_ff @(posedge aclk) begin
      for (int i = 0; i < NUM_BUF; i++) begin
         if (reload_go) begin
            act_mem[i] <= nv_mem[set_req][i];
         end else if (commit_rise) begin
            // Bypass lets one shared strobe load and activate a word
            act_mem[i] <= ctrl_r[CTRL_BCD] ?
                          bcd_to_bin((latch_rise && sel_s2_r == SEL_W'(i)) ? dat_s2_r
                                                                          : buf_mem[i])
                        : ((latch_rise && sel_s2_r == SEL_W'(i)) ? dat_s2_r
                                                                 : buf_mem[i]);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (store_rise) begin
         for (int i = 0; i < NUM_BUF; i++) begin
            nv_mem[active_set_r][i] <= act_mem[i];
         end
      end
   end

   // -------------------------------------------------
   // Loop mode, trim and jog, phase reference
   // -------------------------------------------------
   wire trim_f = pin_s2_r[PIN_TRIMF] & ~pin_s2_r[PIN_TRIMR];
   wire trim_r = pin_s2_r[PIN_TRIMR] & ~pin_s2_r[PIN_TRIMF];
   logic loop_r, trim_f_r, trim_r_r, jog_f_r, jog_r_r, phase_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loop_r   <= 1'b0;
         trim_f_r <= 1'b0;
         trim_r_r <= 1'b0;
         jog_f_r  <= 1'b0;
         jog_r_r  <= 1'b0;
         phase_r  <= 1'b0;
      end else begin
         loop_r   <= ~pin_s2_r[PIN_RESET] & ready_r;
         trim_f_r <= trim_f & ~line_stationary;
         trim_r_r <= trim_r & ~line_stationary;
         jog_f_r  <= trim_f & line_stationary;
         jog_r_r  <= trim_r & line_stationary;
         phase_r  <= cut_rise;
      end
   end

   // -------------------------------------------------
   // Print mark registration
   // -------------------------------------------------
   logic        track_r, tol_r;
   logic [31:0] ref_r, target_r;
   logic [1:0]  miss_r;
   wire  [31:0] spacing  = {12'h0, act_mem[IDX_SPACING]};
   wire  [31:0] win      = {12'h0, act_mem[IDX_WINDOW]};
   wire  [31:0] expected = ref_r + spacing;
   wire         in_win   = (line_pos >= expected - win) && (line_pos <= expected + win);
   wire         overrun  = line_pos > expected + win;
   wire         mark_en  = ctrl_r[CTRL_MARKEN];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         track_r  <= 1'b0;
         ref_r    <= '0;
         miss_r   <= '0;
         tol_r    <= 1'b0;
         target_r <= '0;
      end else begin
         tol_r    <= mark_en & ~track_r;
         target_r <= ref_r + {12'h0, act_mem[IDX_DIST]};
         if (mark_rise && pin_s2_r[PIN_MRST]) begin
            ref_r   <= line_pos;
            track_r <= 1'b1;
            miss_r  <= '0;
         end else if (track_r) begin
            if (mark_rise && in_win) begin
               ref_r  <= line_pos;
               miss_r <= '0;
            end else if (overrun) begin
               // Marks outside the window are ignored; a missed window
               // advances the reference to where the mark belonged
               ref_r  <= expected;
               miss_r <= miss_r + 2'h1;
               if (miss_r == MISS_LIMIT - 2'h1) begin
                  track_r <= 1'b0;
               end
            end
         end else if (mark_rise && mark_en) begin
            ref_r   <= line_pos;
            track_r <= 1'b1;
            miss_r  <= '0;
         end
      end
   end

   // -------------------------------------------------
   // AXI4-Lite slave
   // -------------------------------------------------
   logic              aw_full_r, w_full_r, bvalid_r, rvalid_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0]       w_data_r, rdata_r;
   logic [3:0]        w_strb_r;
   logic [1:0]        bresp_r, rresp_r;
   wire do_write  = aw_full_r & w_full_r & ~bvalid_r;
   wire wr_ctrl   = aw_addr_r == ADDR_CTRL;
   wire ar_take   = s_axi_arvalid & ~rvalid_r;
   wire is_param  = s_axi_araddr[7:6] == PARAM_PAGE;
   wire rd_hit    = is_param || s_axi_araddr == ADDR_CTRL
                    || s_axi_araddr == ADDR_STATUS || s_axi_araddr == ADDR_MARK;
   wire [31:0] status_w = {24'h0, pin_s2_r[PIN_AUX], tol_r, track_r, active_set_r,
                           state_r, loop_r, ready_r};
   wire [31:0] rd_data  = is_param ? {12'h0, act_mem[s_axi_araddr[5:2]]}
                        : s_axi_araddr == ADDR_CTRL   ? {30'h0, ctrl_r}
                        : s_axi_araddr == ADDR_STATUS ? status_w
                        : s_axi_araddr == ADDR_MARK   ? ref_r : 32'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         rvalid_r  <= 1'b0;
         aw_addr_r <= '0;
         w_data_r  <= '0;
         w_strb_r  <= '0;
         bresp_r   <= RESP_OKAY;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= '0;
         ctrl_r    <= CTRL_RST;
      end else begin
         if (s_axi_awvalid && !aw_full_r) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_full_r) begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
            if (wr_ctrl && w_strb_r[0]) begin
               ctrl_r <= w_data_r[1:0];
            end
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
         if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_data;
            rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // -------------------------------------------------
   // Outputs
   // -------------------------------------------------
   assign s_axi_awready      = ~aw_full_r;
   assign s_axi_wready       = ~w_full_r;
   assign s_axi_bvalid       = bvalid_r;
   assign s_axi_bresp        = bresp_r;
   assign s_axi_arready      = ~rvalid_r;
   assign s_axi_rvalid       = rvalid_r;
   assign s_axi_rdata        = rdata_r;
   assign s_axi_rresp        = rresp_r;
   assign ready_out          = ready_r;
   assign closed_loop_enable = loop_r;
   assign startup_pulse      = startup_r;
   assign cutting_active     = state_r == ST_RUN || state_r == ST_STOPPING;
   assign jog_fwd            = jog_f_r;
   assign jog_rev            = jog_r_r;
   assign trim_fwd_out       = trim_f_r;
   assign trim_rev_out       = trim_r_r;
   assign mark_window_open   = track_r & in_win;
   assign cut_too_short      = tol_r;
   assign cut_too_long       = tol_r;
   assign phase_ref_pulse    = phase_r;
   assign cut_target         = target_r;

   // -------------------------------------------------
   // Checks
   // -------------------------------------------------
   latch_store_a: assert property (latch_rise |=>
      buf_mem[$past(sel_s2_r)] == $past(dat_s2_r)) else $error("latch lost");
   commit_copy_a: assert property (commit_rise && !latch_rise && !ctrl_r[CTRL_BCD]
      && !reload_go |=> act_mem[0] == $past(buf_mem[0])) else $error("commit lost");
   joint_load_a: assert property (latch_rise && commit_rise && !ctrl_r[CTRL_BCD]
      && !reload_go |=> act_mem[$past(sel_s2_r)] == $past(dat_s2_r))
      else $error("joint load");
   loop_off_a: assert property (pin_s2_r[PIN_RESET] |=> !closed_loop_enable)
      else $error("loop on in reset");
   restart_load_a: assert property (restart |=> startup_pulse && state_r == ST_LOAD)
      else $error("no restart");
   trim_shift_a: assert property (trim_f && !line_stationary |=> trim_fwd_out && !jog_fwd)
      else $error("trim");
   jog_roll_a: assert property (trim_r && line_stationary |=> jog_rev && !trim_rev_out)
      else $error("jog");
   stop_after_cut_a: assert property (state_r == ST_STOPPING && start_hi && !cut_rise
      && !restart |=> state_r == ST_STOPPING) else $error("stopped early");
   set_hold_a: assert property (state_r == ST_RUN |=> $stable(active_set_r))
      else $error("set changed running");
   nv_store_a: assert property (store_rise |=>
      nv_mem[$past(active_set_r)][0] == $past(act_mem[0])) else $error("store");
   mark_ref_a: assert property (mark_rise && pin_s2_r[PIN_MRST] |=>
      ref_r == $past(line_pos) && track_r) else $error("mark ref");
   tol_flag_a: assert property (mark_en && !track_r ##1 mark_en
      |-> cut_too_short && cut_too_long) else $error("tolerance");
endmodule // cutter_control_input_port
`default_nettype wire

// ===== hw/cutter_pkg.sv
// Shared constants for the cutter control-input port.
// Assumes a single 100 MHz clock and an AXI4-Lite register bus.
`default_nettype none
package cutter_pkg;
   // -------------------------------------------------
   // Parameter port geometry
   // -------------------------------------------------
   localparam int NUM_BUF  = 16;
   localparam int SEL_W    = 4;
   localparam int DATA_W   = 20;
   localparam int NUM_SETS = 2;
   // -------------------------------------------------
   // Control input bit positions in the sync vector
   // -------------------------------------------------
   localparam int PIN_RESET  = 0;
   localparam int PIN_TRIMF  = 1;
   localparam int PIN_TRIMR  = 2;
   localparam int PIN_LATCH  = 3;
   localparam int PIN_COMMIT = 4;
   localparam int PIN_SETSEL = 5;
   localparam int PIN_STORE  = 6;
   localparam int PIN_START  = 7;
   localparam int PIN_MRST   = 8;
   localparam int PIN_MARK   = 9;
   localparam int PIN_CUT    = 10;
   localparam int PIN_AUX    = 11;
   localparam int NUM_PINS   = 12;
   // -------------------------------------------------
   // Register map
   // -------------------------------------------------
   localparam int         ADDR_W      = 8;
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MARK   = 8'h08;
   localparam logic [1:0] PARAM_PAGE  = 2'h1;
   localparam int         CTRL_BCD    = 0;
   localparam int         CTRL_MARKEN = 1;
   localparam logic [1:0] CTRL_RST    = 2'h0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // -------------------------------------------------
   // Parameter word indices, mark tracking and sequencer
   // -------------------------------------------------
   localparam logic [3:0] IDX_SPACING = 4'h1;
   localparam logic [3:0] IDX_DIST    = 4'h2;
   localparam logic [3:0] IDX_WINDOW  = 4'h3;
   localparam logic [1:0] MISS_LIMIT  = 2'h3;
   localparam logic [1:0] LOAD_WAIT   = 2'h3;
   typedef enum logic [1:0] {
      ST_LOAD     = 2'b00,
      ST_RUN      = 2'b01,
      ST_STOPPING = 2'b10,
      ST_STOPPED  = 2'b11
   } ctl_state_e;
endpackage
`default_nettype wire

// ===== testbench/cutter_plc_model.sv
// PLC-side model: parallel parameter port and cutting-pulse source.
// Assumes its tasks are called just after a rising aclk edge.
`default_nettype none
module cutter_plc_model
   import cutter_pkg::*;
(
   input  wire logic              aclk,
   output logic [SEL_W-1:0]       param_select,
   output logic [DATA_W-1:0]      param_data,
   output logic                   buffer_latch_strobe,
   output logic                   buffer_commit_strobe,
   output logic                   nonvolatile_store_strobe,
   output logic                   cutting_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {param_select, param_data} = '0;
      {buffer_latch_strobe, buffer_commit_strobe} = 2'b00;
      {nonvolatile_store_strobe, cutting_pulse} = 2'b00;
   end
   // --------------------------------
   // Word transfer, h cycles each side
   // --------------------------------
   task automatic send(input logic [3:0] s, input logic [19:0] d, input logic l, c, input int h);
      param_select <= s;
      param_data   <= d;
      repeat (h) @(posedge aclk);
      buffer_latch_strobe  <= l;
      buffer_commit_strobe <= c;
      repeat (h) @(posedge aclk);
      buffer_latch_strobe  <= 1'b0;
      buffer_commit_strobe <= 1'b0;
      // Released lines flip, so a late sample cannot match by luck
      param_data   <= ~d;
      param_select <= ~s;
   endtask
   task automatic cut_pulse(input logic st);
      {nonvolatile_store_strobe, cutting_pulse} <= {st, ~st};
      repeat (8) @(posedge aclk);
      {nonvolatile_store_strobe, cutting_pulse} <= 2'b00;
   endtask
endmodule // cutter_plc_model
`default_nettype wire

// ===== testbench/cutter_control_input_port_tb.sv
// Bench for the cutter control-input port: AXI master, pin stimulus, checks.
// Assumes the package and the PLC model are compiled first.
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
   $display("wrong value at %0t: %h expected %h", $time, (a), (e)); end end
module cutter_control_input_port_tb
   import cutter_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, reset_in, trim_fwd_in, trim_rev_in, parameter_set_select, start_stop;
   logic mark_counter_reset, print_mark, aux_in, line_stationary, roll_standstill, ready_out;
   logic buffer_latch_strobe, buffer_commit_strobe, nonvolatile_store_strobe, cutting_pulse;
   logic closed_loop_enable, startup_pulse, cutting_active, jog_fwd, jog_rev, mark_window_open;
   logic cut_too_short, cut_too_long, trim_fwd_out, trim_rev_out, phase_ref_pulse;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0]  param_select, s_axi_wstrb, sel;
   logic [19:0] param_data, w;
   logic [31:0] line_pos, cut_target, s_axi_wdata, s_axi_rdata, rd;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   int          err_total, comparisons, seed, cnt, np, ns;
   cutter_control_input_port i_cutter_control_input_port (.aclk, .aresetn, .reset_in,
      .trim_fwd_in, .trim_rev_in, .buffer_latch_strobe, .buffer_commit_strobe,
      .parameter_set_select, .nonvolatile_store_strobe, .start_stop, .mark_counter_reset,
      .print_mark, .cutting_pulse, .aux_in, .param_select, .param_data, .line_stationary,
      .roll_standstill, .line_pos, .ready_out, .closed_loop_enable, .startup_pulse,
      .cutting_active, .jog_fwd, .jog_rev, .mark_window_open, .cut_too_short, .cut_too_long,
      .trim_fwd_out, .trim_rev_out, .phase_ref_pulse, .cut_target, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   cutter_plc_model i_cutter_plc_model (.aclk, .param_select, .param_data,
      .buffer_latch_strobe, .buffer_commit_strobe, .nonvolatile_store_strobe, .cutting_pulse);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      line_pos <= line_pos + 32'h0000_0001;
      aux_in   <= 1'($random(seed));
      np       += int'(phase_ref_pulse === 1'b1);
      ns       += int'(startup_pulse === 1'b1);
   end
   // --------------------------------
   // Expectations and bus cycles
   // --------------------------------
   function automatic logic [31:0] bcd_val(input logic [19:0] b);
      bcd_val = 32'h0000_0000;
      for (int k = 4; k >= 0; k--) bcd_val = bcd_val * 10 + 32'(b[4*k +: 4]);
   endfunction
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      {rd, rsp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
      `CHK(rd, e)
      `CHK(rsp, er)
   endtask
   task automatic word(input logic [3:0] s, input logic [19:0] d, input logic l, c, input int h);
      i_cutter_plc_model.send(s, d, l, c, h);
      repeat (6) @(posedge aclk);
   endtask
   task automatic wait_ready();
      for (cnt = 0; cnt < 20 && ready_out !== 1'b1; cnt++) @(posedge aclk);
      repeat (2) @(posedge aclk);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (6000) @(posedge aclk);
      err_total++;
      stop_test();
   end
   // --------------------------------
   // Main sequence
   // --------------------------------
   initial begin
      {seed, err_total, comparisons, np, ns, line_pos} = {32'h0000_dc22, 160'h0};
      {aresetn, reset_in, trim_fwd_in, trim_rev_in, parameter_set_select, start_stop} = '0;
      {mark_counter_reset, print_mark, aux_in, line_stationary, roll_standstill} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      wait_ready();
      `CHK(closed_loop_enable, 1'b1)
      rd_chk(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
      rd_chk(8'hfc, 32'h0000_0000, RESP_SLVERR);
      axi_wr(ADDR_STATUS, 32'hffff_ffff);
      `CHK(rsp, RESP_SLVERR)
      for (int i = 0; i < 8; i++) begin
         sel = (i == 0) ? 4'hf : 4'($random(seed));
         w = (i == 0) ? 20'hf_ffff : 20'($random(seed));
         word(sel, w, 1'b1, 1'b1, (i == 1) ? 40 : 4);
         rd_chk({PARAM_PAGE, sel, 2'b00}, {12'h000, w}, RESP_OKAY);
         word(sel, ~w, 1'b1, 1'b0, 4);
         rd_chk({PARAM_PAGE, sel, 2'b00}, {12'h000, w}, RESP_OKAY);
         word(sel, w, 1'b0, 1'b1, 4);
         rd_chk({PARAM_PAGE, sel, 2'b00}, {12'h000, ~w}, RESP_OKAY);
      end
      $display("test parameter words done");
      axi_wr(ADDR_CTRL, 32'h0000_0001);
      rd_chk(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         for (int k = 0; k < 5; k++) w[4*k +: 4] = (i == 0) ? 4'h9 : 4'({$random(seed)} % 10);
         word(IDX_DIST, w, 1'b1, 1'b1, 4);
         rd_chk({PARAM_PAGE, IDX_DIST, 2'b00}, bcd_val(w), RESP_OKAY);
      end
      word(IDX_SPACING, 20'h9_9999, 1'b1, 1'b1, 4);
      axi_wr(ADDR_CTRL, 32'h0000_0002);
      $display("test digit mode done");
      for (int d = 0; d < 4; d++) begin
         {line_stationary, trim_rev_in} <= 2'(d);
         trim_fwd_in <= ~d[0];
         repeat (6) @(posedge aclk);
         sel = d[1] ? {~d[0], d[0], 2'b00} : {2'b00, ~d[0], d[0]};
         `CHK({jog_fwd, jog_rev, trim_fwd_out, trim_rev_out}, sel)
      end
      {trim_fwd_in, trim_rev_in} <= 2'b00;
      $display("test trim done");
      `CHK({cut_too_short, cut_too_long}, 2'b11)
      rd = line_pos + 32'h0000_0003;
      {mark_counter_reset, print_mark} <= 2'b11;
      repeat (6) @(posedge aclk);
      mark_counter_reset <= 1'b0;
      `CHK({cut_too_short, cut_too_long, cut_target}, {2'b00, rd + bcd_val(w)})
      rd_chk(ADDR_MARK, rd, RESP_OKAY);
      `CHK(cutting_active, 1'b1)
      start_stop <= 1'b1;
      repeat (6) @(posedge aclk);
      `CHK(cutting_active, 1'b1)
      np = 0;
      i_cutter_plc_model.cut_pulse(1'b0);
      repeat (6) @(posedge aclk);
      `CHK(np, 1)
      `CHK(cutting_active, 1'b0)
      i_cutter_plc_model.cut_pulse(1'b1);
      ns = 0;
      reset_in <= 1'b1;
      repeat (8) @(posedge aclk);
      `CHK(ns, 1)
      `CHK(closed_loop_enable, 1'b0)
      wait_ready();
      rd_chk({PARAM_PAGE, IDX_DIST, 2'b00}, bcd_val(w), RESP_OKAY);
      {reset_in, start_stop} <= 2'b00;
      repeat (8) @(posedge aclk);
      `CHK(closed_loop_enable, 1'b1)
      `CHK(cutting_active, 1'b1)
      $display("test run control done");
      stop_test();
   end
endmodule // cutter_control_input_port_tb
`default_nettype wire
